// [include/bridge_map.svh]
`ifndef BRIDGE_MAP_SVH
`define BRIDGE_MAP_SVH
`define BR_CLK_HZ 20000000
`define BR_MAX_BAUD 1000000
`define BR_BAD_BAUD 921600
`define BR_BLINK_HZ 4
`define BR_BLINK_CYC (`BR_CLK_HZ / (2 * `BR_BLINK_HZ))
`define BR_RST_PULSE_US 10
`define BR_RST_CYC ((`BR_RST_PULSE_US * (`BR_CLK_HZ / 1000000)))
`endif

// [include/bridge_pkg.sv]
package bridge_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_DETECT = 5'h02,
    ST_FREE = 5'h04,
    ST_FLOW = 5'h08,
    ST_NOFLOW = 5'h10
  } fc_state_t;
endpackage : bridge_pkg

// [include/uart_tx_if.sv]
interface uart_tx_if;
  logic [7:0] data;
  logic valid;
  logic ready;
  logic tick;
  modport src (output data, output valid, input ready, output tick);
  modport snk (input data, input valid, output ready, input tick);
endinterface : uart_tx_if

// [hw/uart_tx_core.sv]
module uart_tx_core (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  uart_tx_if.snk tx,
  output logic txd_o
);
  logic [3:0] bit_r, bit_nxt;
  logic [8:0] sh_r, sh_nxt;
  logic txd_r, txd_nxt;

  // Shift start, data, stop one bit per baud tick
  assign tx.ready = (bit_r == 4'h0);
  assign txd_o = txd_r;

  always_comb begin
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    txd_nxt = txd_r;
    if (bit_r == 4'h0) begin
      if (tx.valid) begin
        sh_nxt = {1'b1, tx.data};
        bit_nxt = 4'hA;
      end
    end else if (tx.tick) begin
      if (bit_r == 4'hA) begin
        txd_nxt = 1'b0; // Start bit
      end else begin
        txd_nxt = sh_r[0];
        sh_nxt = {1'b1, sh_r[8:1]};
      end
      bit_nxt = bit_r - 4'h1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bit_r <= 4'h0;
      sh_r <= 9'h1FF;
      txd_r <= 1'b1;
    end else begin
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      txd_r <= txd_nxt;
    end
  end
endmodule : uart_tx_core

// [hw/debug_probe_uart_bridge.sv]
`include "bridge_map.svh"
module debug_probe_uart_bridge #(
  parameter int BLINK_CYC = `BR_BLINK_CYC,
  parameter int RST_CYC = `BR_RST_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic host_dtr_i,
  input wire logic alt_firmware_i,
  input wire logic [20:0] baud_rate_i,
  output logic baud_ok_o,
  input wire logic [7:0] host_tx_data_i,
  input wire logic host_tx_valid_i,
  output logic host_tx_ready_o,
  output logic [7:0] host_rx_data_o,
  output logic host_rx_valid_o,
  input wire logic host_rx_ready_i,
  output logic target_rxd_o,
  output logic target_rxd_oe_o,
  input wire logic target_txd_i,
  output logic target_cts_o,
  output logic target_cts_oe_o,
  input wire logic target_rts_i,
  output logic hardware_flow_control_o,
  input wire logic boot_reset_button_n_i,
  input wire logic target_pin_reset_option_i,
  output logic target_reset_n_o,
  output logic target_reset_n_oe_o,
  output logic boot_status_led_n_o,
  output logic bootloader_mode_o,
  input wire logic image_write_i,
  input wire logic image_is_hex_i,
  output logic program_start_o,
  input wire logic drive_cmd_valid_i,
  input wire logic drive_cmd_enable_i,
  input wire logic drive_setting_saved_i,
  output logic drive_setting_o,
  output logic drive_setting_save_o,
  output logic mass_storage_drive_o
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0] s1_r, s2_r;
  // No reset here: the pins must be seen through reset, or a held button
  // and a raised DTR would read as their reset constants at strap time
  always_ff @(posedge sys_clk_i) begin
    s1_r <= {target_txd_i, target_rts_i, boot_reset_button_n_i, host_dtr_i};
    s2_r <= s1_r;
  end
  logic dtr_s, btn_s, rts_s, rxd_s;
  assign dtr_s = ~s2_r[0] ? 1'b0 : 1'b1;
  assign btn_s = ~s2_r[1];
  assign rts_s = s2_r[2];
  assign rxd_s = s2_r[3];
  logic dtr_d_r;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) dtr_d_r <= 1'b0;
    else dtr_d_r <= dtr_s;
  end
  logic dtr_rise;
  assign dtr_rise = dtr_s & ~dtr_d_r;

  // ----------------------------------------
  // Baud divider
  // ----------------------------------------
  // Rate checked every cycle; a refused rate keeps the link silent
  function automatic logic rate_ok(input logic [20:0] b);
    rate_ok = (b != 21'h0) && (b <= 21'(`BR_MAX_BAUD)) && (b != 21'(`BR_BAD_BAUD));
  endfunction : rate_ok
  assign baud_ok_o = rate_ok(baud_rate_i);
  logic [24:0] acc_r, acc_nxt;
  logic tick_r, tick_nxt;
  always_comb begin
    acc_nxt = acc_r + {4'h0, baud_rate_i};
    tick_nxt = 1'b0;
    if (!baud_ok_o) begin
      acc_nxt = 25'h0;
    end else if (acc_nxt >= 25'(`BR_CLK_HZ)) begin
      acc_nxt = acc_nxt - 25'(`BR_CLK_HZ);
      tick_nxt = 1'b1;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      acc_r <= 25'h0;
      tick_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      tick_r <= tick_nxt;
    end
  end

  // ----------------------------------------
  // Flow-control detection
  // ----------------------------------------
  bridge_pkg::fc_state_t st_r, st_nxt;
  logic first_word;
  logic rx_word;
  logic tx_take;
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      bridge_pkg::ST_IDLE: if (dtr_s) st_nxt = alt_firmware_i ? bridge_pkg::ST_NOFLOW
                                              : bridge_pkg::ST_DETECT;
      bridge_pkg::ST_DETECT: if (first_word) begin
        st_nxt = rts_s ? bridge_pkg::ST_FREE : bridge_pkg::ST_FLOW;
      end
      bridge_pkg::ST_FREE, bridge_pkg::ST_FLOW, bridge_pkg::ST_NOFLOW: begin
        if (dtr_rise) st_nxt = alt_firmware_i ? bridge_pkg::ST_NOFLOW
                                              : bridge_pkg::ST_DETECT;
      end
      default: st_nxt = bridge_pkg::ST_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) st_r <= bridge_pkg::ST_IDLE;
    else st_r <= st_nxt;
  end
  assign first_word = rx_word | tx_take;
  // Lines float until a terminal opened the port once; CTS is driven only while detecting and in flow mode
  assign target_rxd_oe_o = (st_r != bridge_pkg::ST_IDLE);
  assign target_cts_oe_o = (st_r == bridge_pkg::ST_DETECT) ||
                           (st_r == bridge_pkg::ST_FLOW);
  assign hardware_flow_control_o = (st_r == bridge_pkg::ST_FLOW);

  // ----------------------------------------
  // Transmit toward target
  // ----------------------------------------
  uart_tx_if txb();
  logic fc_hold;
  // Target RTS high pauses us only when handshake is in use
  assign fc_hold = hardware_flow_control_o & rts_s;
  assign txb.data = host_tx_data_i;
  assign txb.valid = host_tx_valid_i & target_rxd_oe_o & ~fc_hold & baud_ok_o;
  assign txb.tick = tick_r;
  assign host_tx_ready_o = txb.ready & target_rxd_oe_o & ~fc_hold & baud_ok_o;
  assign tx_take = txb.valid & txb.ready;
  uart_tx_core u_tx (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .tx(txb),
    .txd_o(target_rxd_o)
  );

  // ----------------------------------------
  // Receive from target
  // ----------------------------------------
  // Mid-bit sampling at 16x would cost a second divider; tick-aligned sampling is enough here
  logic [3:0] rbit_r, rbit_nxt;
  logic [7:0] rsh_r, rsh_nxt;
  logic [7:0] rdat_r, rdat_nxt;
  logic rval_r, rval_nxt;
  always_comb begin
    rbit_nxt = rbit_r;
    rsh_nxt = rsh_r;
    rdat_nxt = rdat_r;
    rval_nxt = rval_r & ~host_rx_ready_i;
    rx_word = 1'b0;
    if (tick_r && target_rxd_oe_o) begin
      if (rbit_r == 4'h0) begin
        if (!rxd_s) rbit_nxt = 4'h9;
      end else if (rbit_r == 4'h1) begin
        rbit_nxt = 4'h0;
        if (rxd_s) begin
          rdat_nxt = rsh_r;
          rval_nxt = 1'b1;
          rx_word = 1'b1;
        end
      end else begin
        rsh_nxt = {rxd_s, rsh_r[7:1]};
        rbit_nxt = rbit_r - 4'h1;
      end
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rbit_r <= 4'h0;
      rsh_r <= 8'h00;
      rdat_r <= 8'h00;
      rval_r <= 1'b0;
    end else begin
      rbit_r <= rbit_nxt;
      rsh_r <= rsh_nxt;
      rdat_r <= rdat_nxt;
      rval_r <= rval_nxt;
    end
  end
  assign host_rx_data_o = rdat_r;
  assign host_rx_valid_o = rval_r;
  // CTS low lets the target send while our receive slot is free
  assign target_cts_o = rval_r & (st_r == bridge_pkg::ST_FLOW);

  // ----------------------------------------
  // Button, bootloader, reset pulse
  // ----------------------------------------
  logic boot_r, boot_nxt, strap_r, strap_nxt;
  logic [22:0] cnt_r, cnt_nxt;
  logic led_r, led_nxt, btn_d_r;
  logic [15:0] rcnt_r, rcnt_nxt;
  always_comb begin
    strap_nxt = 1'b1;
    boot_nxt = strap_r ? boot_r : btn_s;
    cnt_nxt = cnt_r;
    led_nxt = led_r;
    rcnt_nxt = rcnt_r;
    if (boot_r) begin
      cnt_nxt = cnt_r + 23'h1;
      if (cnt_r >= 23'(BLINK_CYC - 1)) begin
        cnt_nxt = 23'h0;
        led_nxt = ~led_r;
      end
    end
    if (rcnt_r != 16'h0) rcnt_nxt = rcnt_r - 16'h1;
    else if (strap_r && !boot_r && btn_s && !btn_d_r &&
             target_pin_reset_option_i) rcnt_nxt = 16'(RST_CYC);
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      strap_r <= 1'b0;
      boot_r <= 1'b0;
      cnt_r <= 23'h0;
      led_r <= 1'b1;
      rcnt_r <= 16'h0;
      btn_d_r <= 1'b0;
    end else begin
      strap_r <= strap_nxt;
      boot_r <= boot_nxt;
      cnt_r <= cnt_nxt;
      led_r <= led_nxt;
      rcnt_r <= rcnt_nxt;
      btn_d_r <= btn_s;
    end
  end
  assign bootloader_mode_o = boot_r;
  assign boot_status_led_n_o = led_r;
  assign target_reset_n_o = 1'b0;
  assign target_reset_n_oe_o = (rcnt_r != 16'h0);

  // ----------------------------------------
  // Mass storage drive
  // ----------------------------------------
  // Setting captured once after reset; commands only touch the saved copy
  logic drv_r, drv_nxt, prog_r, prog_nxt, set_r, set_nxt, sv_r, sv_nxt;
  always_comb begin
    drv_nxt = strap_r ? drv_r : drive_setting_saved_i;
    set_nxt = set_r;
    sv_nxt = 1'b0;
    if (drive_cmd_valid_i) begin
      set_nxt = drive_cmd_enable_i;
      sv_nxt = 1'b1;
    end
    prog_nxt = drv_r & ~boot_r & image_write_i & image_is_hex_i;
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      drv_r <= 1'b0;
      set_r <= 1'b1;
      sv_r <= 1'b0;
      prog_r <= 1'b0;
    end else begin
      drv_r <= drv_nxt;
      set_r <= set_nxt;
      sv_r <= sv_nxt;
      prog_r <= prog_nxt;
    end
  end
  assign mass_storage_drive_o = drv_r;
  assign drive_setting_o = set_r;
  assign drive_setting_save_o = sv_r;
  assign program_start_o = prog_r;
endmodule : debug_probe_uart_bridge

// [dv/bridge_props.sv]
module bridge_props #(
  parameter int BLINK_CYC = 8,
  parameter int RST_CYC = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic host_dtr_i,
  input wire logic [20:0] baud_rate_i,
  input wire logic baud_ok_o,
  input wire logic host_tx_ready_o,
  input wire logic target_rxd_oe_o,
  input wire logic target_cts_oe_o,
  input wire logic target_rts_i,
  input wire logic hardware_flow_control_o,
  input wire logic target_reset_n_o,
  input wire logic target_reset_n_oe_o,
  input wire logic boot_status_led_n_o,
  input wire logic bootloader_mode_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // Port checks
  // ----------
  localparam int RST_HOLD = RST_CYC - 1;
  localparam int BLINK_M2 = BLINK_CYC - 2;
  logic dtr_seen_r;
  logic dtr_seen_nxt;
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  // Raw DTR is seen before the sync stages, so this errs on the safe side
  always_comb dtr_seen_nxt = dtr_seen_r | host_dtr_i;
  always_ff @(posedge sys_clk_i) dtr_seen_r <= rst_i ? 1'b0 : dtr_seen_nxt;
  // Steps of the reset pulse and of one blink half period
  sequence pulse_s;
    (target_reset_n_oe_o && !target_reset_n_o) throughout ##RST_HOLD 1'b1;
  endsequence
  sequence led_hold_s;
    $stable(boot_status_led_n_o) throughout ##BLINK_M2 1'b1;
  endsequence
  idle_float_a: assert property (!dtr_seen_r |-> !target_rxd_oe_o && !target_cts_oe_o)
    else $error("target line driven before DTR");
  baud_check_a: assert property (
    baud_ok_o == (baud_rate_i != 21'h0 && baud_rate_i <= 21'h0F4240 && baud_rate_i != 21'h0E1000))
    else $error("baud accept wrong");
  flow_refuse_a: assert property (
    target_rts_i [*3] ##0 hardware_flow_control_o |-> !host_tx_ready_o)
    else $error("byte taken while target stops");
  cts_hold_a: assert property (hardware_flow_control_o |-> target_cts_oe_o)
    else $error("CTS released in flow mode");
  rst_pulse_a: assert property ($rose(target_reset_n_oe_o) |-> pulse_s ##1 !target_reset_n_oe_o)
    else $error("reset pulse length wrong");
  rst_low_a: assert property (target_reset_n_oe_o |-> !target_reset_n_o)
    else $error("reset line driven high");
  led_off_a: assert property (!bootloader_mode_o |-> boot_status_led_n_o)
    else $error("LED lit outside bootloader");
  led_blink_a: assert property (bootloader_mode_o && $changed(boot_status_led_n_o) |=>
    led_hold_s ##1 $changed(boot_status_led_n_o))
    else $error("blink period wrong");
endmodule : bridge_props

bind debug_probe_uart_bridge bridge_props #(.BLINK_CYC(BLINK_CYC), .RST_CYC(RST_CYC))
  bridge_props_inst (.*);

// [dv/target_model.sv]
module target_model (
  input wire logic sys_clk_i,
  input wire logic rts_level_i,
  input wire logic rxd_i,
  output logic txd_o = 1'b1,
  output logic rts_o,
  output logic [7:0] rx_byte_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // Target UART, 20 cycles a bit
  // ----------
  // Request-to-send level as the scenario commands it
  assign rts_o = rts_level_i;
  // Mid-bit sampling on the falling edge, away from the launch edge
  always begin
    @(negedge rxd_i);
    repeat (30) @(negedge sys_clk_i);
    for (int i = 0; i < 8; i++) begin
      rx_byte_o[i] = rxd_i;
      repeat (20) @(negedge sys_clk_i);
    end
  end
  task automatic send_byte(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk_i);
      txd_o <= f[i];
      repeat (19) @(posedge sys_clk_i);
    end
  endtask : send_byte
endmodule : target_model

// [dv/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // Bench
  // ----------
  logic sys_clk_i = 1'b0, rst_i = 1'b1, host_dtr_i = 1'b0, alt_firmware_i = 1'b0;
  logic host_tx_valid_i = 1'b0, host_rx_ready_i = 1'b0, boot_reset_button_n_i = 1'b1;
  logic target_pin_reset_option_i = 1'b1, image_write_i = 1'b0, image_is_hex_i = 1'b0;
  logic drive_cmd_valid_i = 1'b0, drive_cmd_enable_i = 1'b0, drive_setting_saved_i = 1'b1;
  logic rts_lvl = 1'b1;
  logic [20:0] baud_rate_i = 21'h0F4240;
  logic [7:0] host_tx_data_i = 8'h00, host_rx_data_o, rx_byte;
  logic baud_ok_o, host_tx_ready_o, host_rx_valid_o, target_rxd_o, target_rxd_oe_o;
  logic target_cts_o, target_cts_oe_o, hardware_flow_control_o, target_reset_n_o;
  logic target_reset_n_oe_o, boot_status_led_n_o, bootloader_mode_o, program_start_o;
  logic drive_setting_o, drive_setting_save_o, mass_storage_drive_o;
  wire target_txd_i, target_rts_i;
  // Released line idles high, as a UART line does
  wire rxd_line = target_rxd_oe_o ? target_rxd_o : 1'b1;
  int failures = 0, samples_checked = 0, n;
  always #25 sys_clk_i = ~sys_clk_i;
  debug_probe_uart_bridge #(.BLINK_CYC(8), .RST_CYC(4)) debug_probe_uart_bridge_inst (.*);
  target_model target_model_inst (.sys_clk_i, .rts_level_i(rts_lvl), .rxd_i(rxd_line),
    .txd_o(target_txd_i), .rts_o(target_rts_i), .rx_byte_o(rx_byte));
  task automatic chk(input string s, input logic [20:0] seen, input logic [20:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", s, exp, seen);
    end
  endtask : chk
  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk_i);
  endtask : tick
  task automatic power_up(input logic btn_n, input logic saved);
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    boot_reset_button_n_i <= btn_n;
    drive_setting_saved_i <= saved;
    tick(12);
    rst_i <= 1'b0;
    tick(4);
    @(negedge sys_clk_i);
  endtask : power_up
  task automatic new_dtr(input logic rts, input logic alt);
    @(posedge sys_clk_i);
    rts_lvl <= rts;
    alt_firmware_i <= alt;
    host_dtr_i <= 1'b0;
    tick(4);
    host_dtr_i <= 1'b1;
    tick(4);
    @(negedge sys_clk_i);
  endtask : new_dtr
  task automatic host_take(input logic [7:0] e, input logic fc);
    for (int k = 0; k < 400 && host_rx_valid_o !== 1'b1; k++) @(negedge sys_clk_i);
    chk("rx_data", host_rx_data_o, e);
    if (fc) chk("cts_pend", {target_cts_oe_o, target_cts_o}, 2'h3);
    @(posedge sys_clk_i);
    host_rx_ready_i <= 1'b1;
    @(posedge sys_clk_i);
    host_rx_ready_i <= 1'b0;
  endtask : host_take
  task automatic t_idle();
    logic [20:0] r[5] = '{21'h0, 21'h0E1000, 21'h0F4241, 21'h01C200, 21'h0F4240};
    chk("oe_idle", {target_rxd_oe_o, target_cts_oe_o}, 2'h0);
    foreach (r[i]) begin
      @(posedge sys_clk_i);
      baud_rate_i <= r[i];
      @(negedge sys_clk_i);
      chk("baud_ok", baud_ok_o, i > 2);
    end
  endtask : t_idle
  task automatic t_free();
    new_dtr(1'b1, 1'b0);
    chk("oe_detect", {target_rxd_oe_o, target_cts_oe_o}, 2'h3);
    @(posedge sys_clk_i);
    host_tx_data_i <= 8'hA5;
    host_tx_valid_i <= 1'b1;
    @(negedge sys_clk_i);
    for (int k = 0; k < 400 && host_tx_ready_o !== 1'b1; k++) @(negedge sys_clk_i);
    @(posedge sys_clk_i);
    host_tx_valid_i <= 1'b0;
    tick(240);
    chk("rx_byte", rx_byte, 8'hA5);
    chk("fc_free", {hardware_flow_control_o, target_cts_oe_o}, 2'h0);
  endtask : t_free
  task automatic t_flow();
    new_dtr(1'b0, 1'b0);
    target_model_inst.send_byte(8'h3C);
    host_take(8'h3C, 1'b1);
    @(posedge sys_clk_i);
    rts_lvl <= 1'b1;
    tick(4);
    @(negedge sys_clk_i);
    chk("fc_refuse", {hardware_flow_control_o, host_tx_ready_o}, 2'h2);
    chk("cts_keep", {target_cts_oe_o, target_cts_o}, 2'h2);
  endtask : t_flow
  task automatic t_alt();
    new_dtr(1'b0, 1'b1);
    target_model_inst.send_byte(8'h5A);
    host_take(8'h5A, 1'b0);
    chk("fc_alt", hardware_flow_control_o, 1'b0);
  endtask : t_alt
  task automatic t_button();
    for (int p = 1; p >= 0; p--) begin
      @(posedge sys_clk_i);
      target_pin_reset_option_i <= p[0];
      boot_reset_button_n_i <= 1'b0;
      n = 0;
      repeat (20) @(negedge sys_clk_i) n += target_reset_n_oe_o;
      chk("rst_pulse", n[20:0], p ? 21'h4 : 21'h0);
      @(posedge sys_clk_i);
      boot_reset_button_n_i <= 1'b1;
      tick(4);
    end
  endtask : t_button
  task automatic t_image();
    for (int h = 0; h < 2; h++) begin
      @(posedge sys_clk_i);
      image_is_hex_i <= h[0];
      image_write_i <= 1'b1;
      @(posedge sys_clk_i);
      image_write_i <= 1'b0;
      @(negedge sys_clk_i);
      chk("prog", program_start_o, h[0]);
      @(negedge sys_clk_i);
      chk("prog_end", program_start_o, 1'b0);
    end
  endtask : t_image
  task automatic t_drive_boot();
    @(posedge sys_clk_i);
    drive_cmd_valid_i <= 1'b1;
    @(posedge sys_clk_i);
    drive_cmd_valid_i <= 1'b0;
    @(negedge sys_clk_i);
    chk("drive_cmd", {drive_setting_save_o, drive_setting_o, mass_storage_drive_o}, 3'h5);
    power_up(1'b0, 1'b0);
    chk("drive_boot", {mass_storage_drive_o, bootloader_mode_o}, 2'h1);
    n = 0;
    // 48 cycles hold exactly three blink periods, whatever the phase
    repeat (48) @(negedge sys_clk_i) n += !boot_status_led_n_o;
    chk("blink", n[20:0], 21'h18);
  endtask : t_drive_boot
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // Watchdog: the sequence needs about 850 cycles
  initial begin
    tick(20000);
    failures++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    power_up(1'b1, 1'b1);
    t_idle();
    t_free();
    t_flow();
    t_alt();
    t_button();
    t_image();
    t_drive_boot();
    tally_and_finish();
  end
endmodule : tb
